// ===== hw/gpiop_ahb_slave.sv
// ahb-lite slave front end: address capture, write strobe, read data
`timescale 1ns/1ns
`default_nettype none
module gpiop_ahb_slave
   import gpiop_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // ahb-lite
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   // register file side
   input  wire logic [15:0] rdData,
   output logic             wrEn,
   output logic [5:0]       regIdx
);
   gpiop_bus_t state_q;
   gpiop_bus_t state_d;
   logic       accept;

   // accept nonseq/seq when selected and bus ready
   assign accept = hsel & htrans[1] & hready & (state_q != BUS_READ);
   assign wrEn   = (state_q == BUS_WRITE);

   // next state: reads take one wait state
   always_comb
   begin
      case (state_q)
         BUS_READ: state_d = BUS_IDLE;
         default:  state_d = accept ? (hwrite ? BUS_WRITE : BUS_READ)
                                    : BUS_IDLE;
      endcase
   end

   // state, address and read data flops
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q   <= BUS_IDLE;
         regIdx    <= 6'h00;
         hreadyout <= 1'b1;
         hrdata    <= 32'h00000000;
      end
      else
      begin
         state_q   <= state_d;
         hreadyout <= (state_d != BUS_READ);
         if (accept)
            regIdx <= haddr[ALSB+5:ALSB];
         if (state_q == BUS_READ)
            hrdata <= {16'h0000, rdData};
      end
   end
endmodule : gpiop_ahb_slave
`default_nettype wire

// ===== hw/gpiop_pin_cell.sv
// one pin: general-purpose decode with special function takeover
`timescale 1ns/1ns
`default_nettype none
module gpiop_pin_cell (
   // general-purpose settings
   input  wire logic dirBit,
   input  wire logic outBit,
   // peripheral side
   input  wire logic sfEn,
   input  wire logic periphOut,
   input  wire logic periphOe,
   // pad controls
   output logic      drvOut,
   output logic      drvOe,
   output logic      pullEn
);
   // peripheral overrides, gpio settings stay stored
   assign drvOe  = sfEn ? periphOe : dirBit;
   assign drvOut = sfEn ? periphOut : outBit;
   // input mode: output bit enables the weak pullup
   assign pullEn = ~sfEn & ~dirBit & outBit;
endmodule : gpiop_pin_cell
`default_nettype wire

// ===== hw/gpiop_pkg.sv
// constants and types shared by the general-purpose port block
package gpiop_pkg;
   // geometry
   localparam int NPORT = 5;
   localparam int PW    = 8;
   localparam int NPIN  = 38;
   localparam int ALSB  = 2;
   // register indices, byte address is four times the index
   localparam logic [5:0] IDX_PORT0_OUTPUT_LATCH = 6'h00;
   localparam logic [5:0] IDX_PORT1_OUTPUT_LATCH = 6'h01;
   localparam logic [5:0] IDX_PORT2_OUTPUT_LATCH = 6'h02;
   localparam logic [5:0] IDX_PORT3_OUTPUT_LATCH = 6'h03;
   localparam logic [5:0] IDX_PORT4_OUTPUT_LATCH = 6'h04;
   localparam logic [5:0] IDX_PORT0_PIN_READBACK = 6'h08;
   localparam logic [5:0] IDX_PORT0_DIRECTION    = 6'h10;
   localparam logic [5:0] IDX_SF_CONTROL         = 6'h18;
   localparam logic [5:0] IDX_EXT_IRQ_ENABLE     = 6'h19;
   localparam logic [5:0] IDX_SYSTEM_CONTROL_REG = 6'h1A;
   // special function control fields
   localparam int SF_IR_ENVELOPE_SELECT_LO  = 0;
   localparam int SF_REN0      = 2;
   localparam int SF_REN1      = 3;
   localparam int SF_TXW0      = 4;
   localparam int SF_CTSEL     = 6;
   localparam int SF_TMROE     = 7;
   localparam int SF_EXENB0    = 8;
   localparam int SF_EXENB1    = 9;
   localparam int SF_RUNCS0_LO = 10;
   localparam int SF_RUNCS1_LO = 12;
   localparam int SF_SPI_BLOCK_ENABLE     = 14;
   localparam int SYS_TAP_BIT  = 7;
   // encodings and reset values
   localparam logic [1:0]  IR_ENVELOPE_SELECT_MOD   = 2'h1;
   localparam logic [1:0]  IR_ENVELOPE_SELECT_ENV   = 2'h2;
   localparam logic [1:0]  RUNCS_OFF   = 2'h0;
   localparam logic [7:0]  PORT_RST    = 8'h00;
   localparam logic [15:0] SFCTL_RST   = 16'h0000;
   localparam logic [15:0] IRQEN_RST   = 16'h0000;
   localparam logic [7:0]  SYSCTL_RST  = 8'h80;
   localparam logic [7:0]  FULL_MASK   = 8'hFF;
   localparam logic [7:0]  P4_MASK     = 8'h3F;
   // pin positions of special functions, pin = port*8+bit
   localparam int PIN_IR       = 0;
   localparam int PIN_RX0      = 1;
   localparam int PIN_TX0      = 2;
   localparam int PIN_TMRIN    = 5;
   localparam int PIN_PWM0     = 6;
   localparam int PIN_IRQ_LO   = 8;
   localparam int PIN_SPI      = 16;
   localparam int PIN_TAP      = 20;
   localparam int PIN_IRQ_HI   = 24;
   localparam int PIN_PORT4    = 32;
   // bus slave states
   typedef enum logic [1:0] {
      BUS_IDLE  = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ  = 2'b10
   } gpiop_bus_t;
endpackage : gpiop_pkg

// ===== hw/gpiop_top.sv
// general-purpose port block: 38 pins, registers on ahb-lite
//
// Behaviour
// - provide 38 pins, eight on ports 0 to 3 and six on port 4
// - direction and output bit decode: three-state, weak pullup, strong drive
// - output latch holds the value driven on every output pin whose special function is off
// - in input mode the output latch bit enables the weak pullup
// - writing a direction register leaves the output latch unchanged
// - after reset all special functions off except the four tap pins
// - pins with special function disabled act as plain gpio
// - port 0 pin 0 carries ir output when envelope select is 01b or 10b
// - port 0 pins 1,3 serial receive; pins 2,4 transmit once buffer written
// - port 0 pin 5 timer input when counter select or output enable set
// - port 0 pins 6,7 pwm when external enable b or run/clock pair nonzero
// - port 1 and port 3 pins are external irq inputs when enabled
// - port 2 pins 0-3 carry spi mosi, miso, sclk, select when spi enabled
// - port 2 pins 4-7 carry tck, tdi, tms, tdo when tap enable bit set
// - pin readback returns the current pin level whatever the direction
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module gpiop_top
   import gpiop_pkg::*;
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // ahb-lite slave
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   output logic                 hreadyout,
   output logic [31:0]          hrdata,
   output logic                 hresp,
   // port pins
   input  wire logic [NPIN-1:0] pinIn,
   output logic [NPIN-1:0]      pinOut,
   output logic [NPIN-1:0]      pinOe,
   output logic [NPIN-1:0]      pinPullEn,
   // peripheral side
   input  wire logic [NPIN-1:0] periphOut,
   input  wire logic [NPIN-1:0] periphOe,
   input  wire logic            tx0BufWrite,
   input  wire logic            tx1BufWrite,
   output logic [NPIN-1:0]      pinLevel,
   output logic [NPIN-1:0]      sfActive
);
   // stored registers
   logic [7:0]      outLatch_q [NPORT];
   logic [7:0]      dir_q      [NPORT];
   logic [15:0]     sfCtl_q;
   logic [15:0]     irqEn_q;
   logic [7:0]      sysCtl_q;
   logic [1:0]      txWr_q;
   logic [1:0]      txWr_d;
   // bus side
   logic            wrEn;
   logic [5:0]      regIdx;
   logic [15:0]     rdData;
   logic [7:0]      inByte     [NPORT];
   logic [39:0]     levelPad;
   // pin decode
   logic [NPIN-1:0] sfEn;
   logic [NPIN-1:0] cellOut;
   logic [NPIN-1:0] cellOe;
   logic [NPIN-1:0] cellPull;
   logic [1:0]      ir_envelope_select;
   logic [1:0]      runCs0;
   logic [1:0]      runCs1;
   logic            hitSf;
   logic            hitIrq;
   logic            hitSys;

   // bus front end
   gpiop_ahb_slave uBus (
      .clk       (clk),
      .rst       (rst),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .rdData    (rdData),
      .wrEn      (wrEn),
      .regIdx    (regIdx)
   );

   // every transfer answers okay, from a flop like every other output
   always_ff @(posedge clk)
      hresp <= 1'b0;

   // per-port output latch and direction register
   for (genvar p = 0; p < NPORT; p++)
   begin : gPort
      localparam logic [5:0] OIDX = IDX_PORT0_OUTPUT_LATCH + 6'(p);
      localparam logic [5:0] DIDX = IDX_PORT0_DIRECTION + 6'(p);
      localparam logic [7:0] MASK = (p == NPORT - 1) ? P4_MASK : FULL_MASK;
      logic hitOut;
      logic hitDir;
      assign hitOut = wrEn & (regIdx == OIDX);
      assign hitDir = wrEn & (regIdx == DIDX);
      // port 4 keeps its two top bits at zero
      always_ff @(posedge clk)
      begin
         if (rst)
            outLatch_q[p] <= PORT_RST;
         else if (hitOut)
            outLatch_q[p] <= hwdata[7:0] & MASK;
      end
      // a direction write never touches the output latch
      always_ff @(posedge clk)
      begin
         if (rst)
            dir_q[p] <= PORT_RST;
         else if (hitDir)
            dir_q[p] <= hwdata[7:0] & MASK;
      end
      // readback byte from the sampled pin levels
      assign inByte[p] = levelPad[p*PW +: PW] & MASK;
   end

   // control register decode
   assign hitSf  = wrEn & (regIdx == IDX_SF_CONTROL);
   assign hitIrq = wrEn & (regIdx == IDX_EXT_IRQ_ENABLE);
   assign hitSys = wrEn & (regIdx == IDX_SYSTEM_CONTROL_REG);

   // transmit-written flags: buffer write wins over a clearing write
   for (genvar k = 0; k < 2; k++)
   begin : gTx
      logic txPulse;
      assign txPulse   = (k == 0) ? tx0BufWrite : tx1BufWrite;
      assign txWr_d[k] = txPulse
                       | (txWr_q[k] & ~(hitSf & ~hwdata[SF_TXW0+k]));
   end

   // enable registers; tap comes out of reset enabled
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sfCtl_q  <= SFCTL_RST;
         irqEn_q  <= IRQEN_RST;
         sysCtl_q <= SYSCTL_RST;
         txWr_q   <= 2'b00;
      end
      else
      begin
         if (hitSf)
            sfCtl_q <= hwdata[15:0];
         if (hitIrq)
            irqEn_q <= hwdata[15:0];
         if (hitSys)
            sysCtl_q <= hwdata[7:0];
         txWr_q <= txWr_d;
      end
   end

   // control fields
   assign ir_envelope_select  = sfCtl_q[SF_IR_ENVELOPE_SELECT_LO +: 2];
   assign runCs0 = sfCtl_q[SF_RUNCS0_LO +: 2];
   assign runCs1 = sfCtl_q[SF_RUNCS1_LO +: 2];

   // special function enables for port 0
   assign sfEn[PIN_IR]    = (ir_envelope_select == IR_ENVELOPE_SELECT_MOD)
                          | (ir_envelope_select == IR_ENVELOPE_SELECT_ENV);
   assign sfEn[PIN_RX0]   = sfCtl_q[SF_REN0];
   assign sfEn[PIN_TX0]   = txWr_q[0];
   assign sfEn[PIN_RX0+2] = sfCtl_q[SF_REN1];
   assign sfEn[PIN_TX0+2] = txWr_q[1];
   assign sfEn[PIN_TMRIN] = sfCtl_q[SF_CTSEL]
                          | sfCtl_q[SF_TMROE];
   assign sfEn[PIN_PWM0]  = sfCtl_q[SF_EXENB0]
                          | (runCs0 != RUNCS_OFF);
   assign sfEn[PIN_PWM0+1] = sfCtl_q[SF_EXENB1]
                           | (runCs1 != RUNCS_OFF);
   // external interrupts on ports 1 and 3
   assign sfEn[PIN_IRQ_LO +: PW] = irqEn_q[7:0];
   assign sfEn[PIN_IRQ_HI +: PW] = irqEn_q[15:8];
   // spi and test access port on port 2
   assign sfEn[PIN_SPI +: 4] = {4{sfCtl_q[SF_SPI_BLOCK_ENABLE]}};
   assign sfEn[PIN_TAP +: 4] = {4{sysCtl_q[SYS_TAP_BIT]}};
   // port 4 has no special functions
   assign sfEn[NPIN-1:PIN_PORT4] = '0;

   // one cell per pin
   for (genvar i = 0; i < NPIN; i++)
   begin : gPin
      gpiop_pin_cell uCell (
         .dirBit    (dir_q[i/PW][i%PW]),
         .outBit    (outLatch_q[i/PW][i%PW]),
         .sfEn      (sfEn[i]),
         .periphOut (periphOut[i]),
         .periphOe  (periphOe[i]),
         .drvOut    (cellOut[i]),
         .drvOe     (cellOe[i]),
         .pullEn    (cellPull[i])
      );
   end

   // pad controls and sampled levels, all registered
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pinOut    <= '0;
         pinOe     <= '0;
         pinPullEn <= '0;
         pinLevel  <= '0;
         sfActive  <= '0;
      end
      else
      begin
         pinOut    <= cellOut;
         pinOe     <= cellOe;
         pinPullEn <= cellPull;
         pinLevel  <= pinIn;
         sfActive  <= sfEn;
      end
   end

   assign levelPad = {2'b00, pinLevel};

   // read data select; unmapped indices read zero
   always_comb
   begin
      rdData = 16'h0000;
      for (int p = 0; p < NPORT; p++)
      begin
         if (regIdx == IDX_PORT0_OUTPUT_LATCH + 6'(p))
            rdData = {8'h00, outLatch_q[p]};
         if (regIdx == IDX_PORT0_PIN_READBACK + 6'(p))
            rdData = {8'h00, inByte[p]};
         if (regIdx == IDX_PORT0_DIRECTION + 6'(p))
            rdData = {8'h00, dir_q[p]};
      end
      if (regIdx == IDX_SF_CONTROL)
         rdData = {sfCtl_q[15:6], txWr_q, sfCtl_q[3:0]};
      if (regIdx == IDX_EXT_IRQ_ENABLE)
         rdData = irqEn_q;
      if (regIdx == IDX_SYSTEM_CONTROL_REG)
         rdData = {8'h00, sysCtl_q};
   end

   // checks on the block's own registers and outputs
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic rdInReq;
   assign rdInReq = hsel & htrans[1] & hready & ~hwrite
                  & (haddr[ALSB+5:ALSB] == IDX_PORT0_PIN_READBACK);

   AST_P4_TOP_ZERO: assert property (
      outLatch_q[NPORT-1][7:6] == 2'b00 && dir_q[NPORT-1][7:6] == 2'b00)
      else $error("port 4 top bits not zero");

   AST_TRISTATE: assert property (
      (!sfEn[PIN_PORT4] && !dir_q[4][0] && !outLatch_q[4][0])
      |=> (!pinOe[PIN_PORT4] && !pinPullEn[PIN_PORT4]))
      else $error("input pin without pullup not three-state");

   AST_DRIVE: assert property (
      (!sfEn[PIN_PORT4+1] && dir_q[4][1])
      |=> (pinOe[PIN_PORT4+1]
           && pinOut[PIN_PORT4+1] == $past(outLatch_q[4][1])))
      else $error("output pin not driving latch value");

   AST_PULLUP: assert property (
      (!sfEn[PIN_PORT4] && !dir_q[4][0] && outLatch_q[4][0])
      |=> (pinPullEn[PIN_PORT4] && !pinOe[PIN_PORT4]))
      else $error("input pin pullup not enabled");

   AST_DIR_KEEPS_OUT: assert property (
      (wrEn && regIdx == IDX_PORT0_DIRECTION)
      |=> $stable(outLatch_q[0]))
      else $error("direction write changed output latch");

   AST_RESET_STATE: assert property (
      $past(rst) |-> (sysCtl_q[SYS_TAP_BIT] && sfCtl_q == SFCTL_RST
                      && irqEn_q == IRQEN_RST && txWr_q == 2'b00))
      else $error("reset left wrong special function enables");

   AST_SPI_FALLBACK: assert property (
      (!sfCtl_q[SF_SPI_BLOCK_ENABLE] && dir_q[2][0])
      |=> (!sfActive[PIN_SPI] && pinOe[PIN_SPI]))
      else $error("disabled spi pin not plain gpio");

   AST_IR_TAKEOVER: assert property (
      (ir_envelope_select == IR_ENVELOPE_SELECT_MOD || ir_envelope_select == IR_ENVELOPE_SELECT_ENV)
      |=> (pinOut[PIN_IR] == $past(periphOut[PIN_IR])
           && pinOe[PIN_IR] == $past(periphOe[PIN_IR])))
      else $error("ir pin not under peripheral control");

   AST_TX_WRITTEN: assert property (
      tx0BufWrite |-> ##2 sfActive[PIN_TX0])
      else $error("transmit pin not taken after buffer write");

   AST_TIMER_PINS: assert property (
      (sfCtl_q[SF_CTSEL] || runCs0 != RUNCS_OFF)
      |=> (sfActive[PIN_TMRIN] || sfActive[PIN_PWM0]))
      else $error("timer pin not taken");

   AST_IRQ_PIN: assert property (
      irqEn_q[8] |=> sfActive[PIN_IRQ_HI])
      else $error("irq 8 enable did not take port 3 pin 0");

   AST_SPI_TAKEOVER: assert property (
      sfCtl_q[SF_SPI_BLOCK_ENABLE]
      |=> (pinOut[PIN_SPI+2] == $past(periphOut[PIN_SPI+2])
           && sfActive[PIN_SPI +: 4] == 4'hF))
      else $error("spi pins not under peripheral control");

   AST_TAP_PINS: assert property (
      sysCtl_q[SYS_TAP_BIT] |=> sfActive[PIN_TAP +: 4] == 4'hF)
      else $error("tap pins not taken");

   AST_READBACK: assert property (
      rdInReq |-> ##2 (hrdata[7:0] == $past(pinIn[7:0], 2)))
      else $error("port 0 readback not pin level");

   AST_LATCH_WRITE: assert property (
      (wrEn && regIdx == IDX_PORT0_OUTPUT_LATCH)
      |=> outLatch_q[0] == $past(hwdata[7:0]))
      else $error("output latch write not stored");

   AST_TX_CLEAR: assert property (
      (hitSf && !hwdata[SF_TXW0+1] && !tx1BufWrite) |=> !txWr_q[1])
      else $error("transmit flag not cleared by zero write");

   COV_READBACK: cover property (rdInReq ##2 hreadyout);
   COV_TX_TAKE: cover property (tx0BufWrite ##2 pinOe[PIN_TX0]);
   COV_PULLUP: cover property (pinPullEn[PIN_PORT4]);
   COV_TAP_OFF: cover property (!sfActive[PIN_TAP]);
endmodule : gpiop_top
`default_nettype wire

// ===== verif/gpiop_pad_model.sv
// pad and external circuit model seen by the port pins
`timescale 1ns/1ns
`default_nettype none
module gpiop_pad_model
   import gpiop_pkg::*;
(
   // clock
   input  wire logic            clk,
   // device pad controls
   input  wire logic [NPIN-1:0] pinOut,
   input  wire logic [NPIN-1:0] pinOe,
   input  wire logic [NPIN-1:0] pinPullEn,
   // external drivers
   input  wire logic [NPIN-1:0] extVal,
   input  wire logic [NPIN-1:0] extEn,
   // resolved pin level
   output logic [NPIN-1:0]      pinIn
);
   logic [NPIN-1:0] floatQ = '0;

   // undriven pins wander every cycle so no test leans on a settled x
   always_ff @(posedge clk)
      floatQ <= ~floatQ;

   // strong device drive wins, then external drive, then the weak pullup
   assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal)
                | (~pinOe & ~extEn & (pinPullEn | floatQ));
endmodule : gpiop_pad_model
`default_nettype wire

// ===== verif/tb_general_purpose_io_ports.sv
// self-checking bench for the general-purpose port block
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, msg) \
   begin \
      nChecks++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp); \
      end \
   end
module tb_general_purpose_io_ports
   import gpiop_pkg::*;
;
   logic            clk, rst, hsel, hwrite, hreadyout, hresp;
   logic            tx0BufWrite, tx1BufWrite;
   logic [1:0]      htrans;
   logic [2:0]      hsize;
   logic [31:0]     haddr, hwdata, hrdata;
   logic [NPIN-1:0] pinIn, pinOut, pinOe, pinPullEn, periphOut, periphOe;
   logic [NPIN-1:0] pinLevel, sfActive, extVal, extEn;
   logic [NPIN-1:0] eSf, eOe, ePu, eDv;
   logic [7:0]      latch [NPORT];
   logic [7:0]      dir [NPORT];
   logic [15:0]     sfc, irq;
   logic [7:0]      sys;
   int              nChecks, miscompares;

   // device and pad model
   gpiop_top dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .pinPullEn(pinPullEn), .periphOut(periphOut), .periphOe(periphOe),
      .tx0BufWrite(tx0BufWrite), .tx1BufWrite(tx1BufWrite),
      .pinLevel(pinLevel), .sfActive(sfActive));
   gpiop_pad_model pad (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
      .pinPullEn(pinPullEn), .extVal(extVal), .extEn(extEn), .pinIn(pinIn));

   // free-running clock
   always #5 clk = ~clk;

   function automatic logic [NPIN-1:0] rnd();
      return NPIN'({$urandom(), $urandom()});
   endfunction : rnd

   // expected register read value
   function automatic logic [31:0] mread(input logic [5:0] idx);
      if (idx inside {[6'h00:6'h04]})
         return {24'h0, latch[idx[2:0]]};
      if (idx inside {[6'h10:6'h14]})
         return {24'h0, dir[idx[2:0]]};
      if (idx == IDX_SF_CONTROL)
         return {16'h0, sfc};
      if (idx == IDX_EXT_IRQ_ENABLE)
         return {16'h0, irq};
      if (idx == IDX_SYSTEM_CONTROL_REG)
         return {24'h0, sys};
      return 32'h0;
   endfunction : mread

   // expected pin controls from the model state
   task automatic calc();
      eSf = '0;
      eSf[PIN_IR] = sfc[1:0] == IR_ENVELOPE_SELECT_MOD || sfc[1:0] == IR_ENVELOPE_SELECT_ENV;
      eSf[4:1] = {sfc[5], sfc[3], sfc[4], sfc[2]};
      eSf[5] = sfc[SF_CTSEL] | sfc[SF_TMROE];
      eSf[6] = sfc[8] | (sfc[11:10] != RUNCS_OFF);
      eSf[7] = sfc[9] | (sfc[13:12] != RUNCS_OFF);
      eSf[15:8] = irq[7:0];
      eSf[19:16] = {4{sfc[SF_SPI_BLOCK_ENABLE]}};
      eSf[23:20] = {4{sys[SYS_TAP_BIT]}};
      eSf[31:24] = irq[15:8];
      for (int i = 0; i < NPIN; i++)
      begin
         eOe[i] = eSf[i] ? periphOe[i] : dir[i / 8][i % 8];
         ePu[i] = !eSf[i] && !dir[i / 8][i % 8] && latch[i / 8][i % 8];
         eDv[i] = eSf[i] ? periphOut[i] : latch[i / 8][i % 8];
      end
   endtask : calc

   // one single ahb-lite transfer, entered just after a rising edge
   task automatic bus(input logic wr, input logic [5:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, idx, 2'h0};
      @(posedge clk);
      while (hreadyout !== 1'b1)
         @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1)
         @(posedge clk);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, idx, d, rd);
      if (idx inside {[6'h00:6'h04]})
         latch[idx[2:0]] = d[7:0] & (idx[2] ? P4_MASK : FULL_MASK);
      else if (idx inside {[6'h10:6'h14]})
         dir[idx[2:0]] = d[7:0] & (idx[2] ? P4_MASK : FULL_MASK);
      else if (idx == IDX_SF_CONTROL)
         sfc = (d[15:0] & 16'h7FCF) | (sfc & d[15:0] & 16'h0030);
      else if (idx == IDX_EXT_IRQ_ENABLE)
         irq = d[15:0];
      else if (idx == IDX_SYSTEM_CONTROL_REG)
         sys = d[7:0];
   endtask : wr

   task automatic rdchk(input logic [5:0] idx);
      logic [31:0] rd;
      bus(1'b0, idx, 32'h0, rd);
      `CHK(rd, mread(idx), "register read")
      `CHK(hresp, 1'b0, "bus response")
   endtask : rdchk

   // every register but the pin readbacks, plus unmapped places
   task automatic rdall();
      for (int i = 0; i < 64; i++)
         if (!(i inside {[8:12]}) && (i < 32 || i == 63))
            rdchk(6'(i));
   endtask : rdall

   task automatic pins();
      logic [NPIN-1:0] seen;
      @(posedge clk);
      #1;
      seen = pinIn;
      @(posedge clk);
      #1;
      calc();
      `CHK(pinLevel, seen, "pin level")
      `CHK(sfActive, eSf, "special active")
      `CHK(pinOe, eOe, "output enable")
      `CHK(pinPullEn, ePu, "pullup")
      `CHK(pinOut & eOe, eDv & eOe, "drive value")
      @(posedge clk);
   endtask : pins

   task automatic txpulse(input int n);
      if (n == 0)
         tx0BufWrite <= 1'b1;
      else
         tx1BufWrite <= 1'b1;
      @(posedge clk);
      if (n == 0)
         tx0BufWrite <= 1'b0;
      else
         tx1BufWrite <= 1'b0;
      sfc[4 + n] = 1'b1;
   endtask : txpulse

   task automatic do_reset();
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int p = 0; p < NPORT; p++)
      begin
         latch[p] = PORT_RST;
         dir[p] = PORT_RST;
      end
      sfc = SFCTL_RST;
      irq = IRQEN_RST;
      sys = SYSCTL_RST;
   endtask : do_reset

   task automatic stop_test();
      $display("checks %0d mismatches %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   // watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test();
   end

   // main sequence
   initial
   begin
      logic [31:0]     rd;
      logic [NPIN-1:0] lv, mk;
      logic [31:0]     gv, ev;
      int              p;
      clk = 1'b0;
      rst = 1'b1;
      hsel = 1'b1;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      tx0BufWrite = 1'b0;
      tx1BufWrite = 1'b0;
      extVal = '0;
      extEn = '0;
      nChecks = 0;
      miscompares = 0;
      rd = $urandom(69785);
      periphOut = rnd();
      periphOe = rnd();
      do_reset();
      rdall();
      pins();
      $display("test reset done");
      // plain gpio decode on random ports
      wr(IDX_SYSTEM_CONTROL_REG, 32'h0);
      repeat (10)
      begin
         p = $urandom_range(4);
         periphOut <= rnd();
         periphOe <= rnd();
         wr(IDX_PORT0_OUTPUT_LATCH + 6'(p), $urandom());
         wr(IDX_PORT0_DIRECTION + 6'(p), $urandom());
         pins();
         wr(IDX_PORT0_DIRECTION + 6'(p), $urandom());
         rdchk(IDX_PORT0_OUTPUT_LATCH + 6'(p));
      end
      $display("test gpio done");
      // readback, first with all pins driven, then with pullups showing
      for (int pass = 0; pass < 2; pass++)
      begin
         extVal <= rnd();
         extEn <= (pass == 0) ? '1 : rnd();
         repeat (2) @(posedge clk);
         calc();
         lv = (eOe & eDv) | (~eOe & extEn & extVal) | (~eOe & ~extEn & ePu);
         mk = eOe | extEn | ePu;
         for (int q = 0; q < NPORT; q++)
         begin
            bus(1'b0, IDX_PORT0_PIN_READBACK + 6'(q), 32'h0, rd);
            gv = rd & 32'(8'(mk >> (8 * q)));
            ev = 32'(8'((lv & mk) >> (8 * q)));
            `CHK(gv, ev, "readback")
         end
      end
      $display("test readback done");
      // every envelope code and every single enable bit
      for (int e = 0; e < 4; e++)
      begin
         wr(IDX_SF_CONTROL, 32'(e));
         pins();
      end
      for (int b = 2; b < 15; b++)
         if (b != 4 && b != 5)
         begin
            wr(IDX_SF_CONTROL, 32'h1 << b);
            pins();
         end
      wr(IDX_EXT_IRQ_ENABLE, $urandom());
      pins();
      wr(IDX_SYSTEM_CONTROL_REG, 32'h80);
      pins();
      rdall();
      $display("test special done");
      // transmit flags: write 1 ignored, pulse sets, write 0 clears
      wr(IDX_SF_CONTROL, 32'h30);
      pins();
      txpulse(0);
      txpulse(1);
      pins();
      wr(IDX_SF_CONTROL, 32'h10);
      pins();
      rdchk(IDX_SF_CONTROL);
      $display("test transmit done");
      // second reset in mid-run
      do_reset();
      rdall();
      pins();
      $display("test rereset done");
      stop_test();
   end
endmodule : tb_general_purpose_io_ports
`default_nettype wire
